// *** aub_pkg.sv ***
// Constants and types for the auto-baud measurement unit.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package aub_pkg;

  // Register byte addresses
  localparam logic [31:0] AUB_ADDR_CONTROL = 32'h40008020;
  localparam logic [31:0] AUB_ADDR_IRQ = 32'h40008030;
  localparam logic [31:0] AUB_ADDR_DIVISOR = 32'h40008034;

  // Control register fields
  localparam int AUB_CTL_RUN = 0;
  localparam int AUB_CTL_MODE = 1;
  localparam int AUB_CTL_RESTART = 2;
  localparam int AUB_CTL_END_CLR = 8;
  localparam int AUB_CTL_TO_CLR = 9;
  localparam logic [31:0] AUB_CTL_RESET = 32'h00000000;

  // Interrupt enable and flag register fields
  localparam int AUB_IRQ_END_EN = 0;
  localparam int AUB_IRQ_TO_EN = 1;
  localparam int AUB_IRQ_END_FLAG = 8;
  localparam int AUB_IRQ_TO_FLAG = 9;

  // Measurement sizes
  localparam int AUB_CNT_WIDTH = 18;
  localparam int AUB_DIV_WIDTH = 16;
  localparam int AUB_DIV_SHIFT = 4;
  localparam logic [4:0] AUB_START_PULSES = 5'h10;
  localparam logic [15:0] AUB_DIV_RESET = 16'h0000;

  typedef enum logic [1:0] {
    AUB_ST_IDLE = 2'b00,
    AUB_ST_WAIT_FALL = 2'b01,
    AUB_ST_COUNT = 2'b10
  } aub_state_type;

  // Controls toward the receive shift register
  typedef struct packed {
    logic shift_reset;
    logic fast_rate;
    logic bit_clk;
  } aub_rx_ctrl_type;

  // Divisor latch load bundle
  typedef struct packed {
    logic load;
    logic [AUB_DIV_WIDTH-1:0] value;
  } aub_div_type;

endpackage

// *** aub_autobaud.sv ***
// Auto-baud measurement unit: times start bit edges on the receive pin,
// loads the divisor latches and raises end and time-out flags.
// Assumes an Avalon-MM master on core_clk and an asynchronous rx_pin.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
module aub_autobaud
  import aub_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_pin,
  output aub_div_type divisor,
  output aub_rx_ctrl_type rx_ctrl,
  output logic end_irq_flag,
  output logic timeout_irq_flag
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic rx_level;
  logic rx_fall;
  logic rx_rise;
  logic run;
  logic mode;
  logic restart_on_timeout;
  logic end_irq_enable;
  logic timeout_irq_enable;
  aub_state_type state;
  aub_state_type next_state;
  logic [AUB_CNT_WIDTH-1:0] count;
  logic [AUB_CNT_WIDTH-1:0] next_count;
  logic [4:0] pulse_count;
  logic bus_take;
  logic wr_ctl;
  logic wr_irq;
  logic start_req;
  logic stop_req;
  logic done;
  logic overflow;
  logic timeout_set;
  logic end_set;

  // Three-stage synchroniser, level accepted when stages two and three agree
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
    end
    else
    begin
      sync1 <= rx_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_level <= 1'b1;
    end
    else if (sync2 == sync3)
    begin
      rx_level <= sync3;
    end
  end

  assign rx_fall = (sync2 == sync3) && rx_level && !sync3;
  assign rx_rise = (sync2 == sync3) && !rx_level && sync3;

  // Bus handshake: request taken while waitrequest is high,
  // completed at the edge where waitrequest is seen low
  assign bus_take = (avs_read || avs_write) && avs_waitrequest;
  assign wr_ctl = avs_write && !avs_waitrequest && (avs_address == AUB_ADDR_CONTROL);
  assign wr_irq = avs_write && !avs_waitrequest && (avs_address == AUB_ADDR_IRQ);
  assign start_req = wr_ctl && avs_byteenable[0] && avs_writedata[AUB_CTL_RUN] && !run;
  assign stop_req = wr_ctl && avs_byteenable[0] && !avs_writedata[AUB_CTL_RUN];

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !bus_take;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (bus_take && avs_read)
    begin
      avs_readdata <= 32'h00000000;
      unique case (avs_address)
        AUB_ADDR_CONTROL:
        begin
          avs_readdata[AUB_CTL_RUN] <= run;
          avs_readdata[AUB_CTL_MODE] <= mode;
          avs_readdata[AUB_CTL_RESTART] <= restart_on_timeout;
        end
        AUB_ADDR_IRQ:
        begin
          avs_readdata[AUB_IRQ_END_EN] <= end_irq_enable;
          avs_readdata[AUB_IRQ_TO_EN] <= timeout_irq_enable;
          avs_readdata[AUB_IRQ_END_FLAG] <= end_irq_flag;
          avs_readdata[AUB_IRQ_TO_FLAG] <= timeout_irq_flag;
        end
        AUB_ADDR_DIVISOR:
        begin
          avs_readdata[AUB_DIV_WIDTH-1:0] <= divisor.value;
        end
        default:
        begin
          avs_readdata <= 32'h00000000;
        end
      endcase
    end
  end

  // Mode and restart settings
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode <= AUB_CTL_RESET[AUB_CTL_MODE];
      restart_on_timeout <= AUB_CTL_RESET[AUB_CTL_RESTART];
    end
    else if (wr_ctl && avs_byteenable[0])
    begin
      mode <= avs_writedata[AUB_CTL_MODE];
      restart_on_timeout <= avs_writedata[AUB_CTL_RESTART];
    end
  end

  // Interrupt enables
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      end_irq_enable <= 1'b0;
      timeout_irq_enable <= 1'b0;
    end
    else if (wr_irq && avs_byteenable[0])
    begin
      end_irq_enable <= avs_writedata[AUB_IRQ_END_EN];
      timeout_irq_enable <= avs_writedata[AUB_IRQ_TO_EN];
    end
  end

  // Measurement sequencer
  assign overflow = (state == AUB_ST_COUNT) && (&count);
  assign done = (state == AUB_ST_COUNT) && !overflow
    && (mode ? rx_rise : rx_fall);

  always_comb
  begin
    next_state = state;
    next_count = count;
    if (start_req)
    begin
      next_state = AUB_ST_WAIT_FALL;
      next_count = '0;
    end
    else if (stop_req)
    begin
      next_state = AUB_ST_IDLE;
    end
    else
    begin
      unique case (state)
        AUB_ST_IDLE:
        begin
          next_state = AUB_ST_IDLE;
        end
        AUB_ST_WAIT_FALL:
        begin
          if (rx_fall)
          begin
            next_state = AUB_ST_COUNT;
            next_count = {{(AUB_CNT_WIDTH-1){1'b0}}, 1'b1};
          end
        end
        AUB_ST_COUNT:
        begin
          if (overflow)
          begin
            next_count = '0;
            next_state = restart_on_timeout ? AUB_ST_WAIT_FALL : AUB_ST_IDLE;
          end
          else if (done)
          begin
            next_state = AUB_ST_IDLE;
          end
          else
          begin
            next_count = count + {{(AUB_CNT_WIDTH-1){1'b0}}, 1'b1};
          end
        end
        default:
        begin
          next_state = AUB_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= AUB_ST_IDLE;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Run bit follows the sequencer; cleared by hardware when finished
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run <= AUB_CTL_RESET[AUB_CTL_RUN];
    end
    else
    begin
      run <= (next_state != AUB_ST_IDLE);
    end
  end

  // Divisor load on a completed measurement only
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divisor.load <= 1'b0;
      divisor.value <= AUB_DIV_RESET;
    end
    else
    begin
      divisor.load <= done && !start_req && !stop_req;
      if (done && !start_req && !stop_req)
      begin
        divisor.value <= {2'b00, count[AUB_CNT_WIDTH-1:AUB_DIV_SHIFT]};
      end
    end
  end

  // Shift register controls: reset, fast rate, start-bit pulses
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_ctrl.shift_reset <= 1'b0;
      rx_ctrl.fast_rate <= 1'b0;
      rx_ctrl.bit_clk <= 1'b0;
    end
    else
    begin
      rx_ctrl.shift_reset <= start_req;
      rx_ctrl.fast_rate <= (next_state != AUB_ST_IDLE);
      rx_ctrl.bit_clk <= (next_state == AUB_ST_COUNT)
        && (pulse_count != AUB_START_PULSES);
    end
  end

  // Start-bit pulse counter
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pulse_count <= 5'h00;
    end
    else if (next_state != AUB_ST_COUNT)
    begin
      pulse_count <= 5'h00;
    end
    else if (pulse_count != AUB_START_PULSES)
    begin
      pulse_count <= pulse_count + 5'h01;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  assign timeout_set = overflow && !start_req && !stop_req && timeout_irq_enable;
  assign end_set = divisor.load && end_irq_enable;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      end_irq_flag <= 1'b0;
    end
    else if (end_set)
    begin
      end_irq_flag <= 1'b1;
    end
    else if (wr_ctl && avs_byteenable[1] && avs_writedata[AUB_CTL_END_CLR])
    begin
      end_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timeout_irq_flag <= 1'b0;
    end
    else if (timeout_set)
    begin
      timeout_irq_flag <= 1'b1;
    end
    else if (wr_ctl && avs_byteenable[1] && avs_writedata[AUB_CTL_TO_CLR])
    begin
      timeout_irq_flag <= 1'b0;
    end
  end

endmodule

// *** aub_autobaud_sva.sv ***
// Checker for the auto-baud unit.
// Assumes only the top module ports are visible.
`timescale 1ns/1ns
module aub_chk
  import aub_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire aub_div_type divisor,
  input wire aub_rx_ctrl_type rx_ctrl,
  input wire logic end_irq_flag,
  input wire logic timeout_irq_flag
);
  logic ctl_wr;
  assign ctl_wr = avs_write && !avs_waitrequest && avs_address == AUB_ADDR_CONTROL;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_load;
    divisor.load |=> !divisor.load;
  endproperty
  a_load: assert property (p_load) else $error("long load");
  property p_end;
    $rose(end_irq_flag) |-> $past(divisor.load);
  endproperty
  a_end: assert property (p_end) else $error("end flag early");
  property p_rate;
    divisor.load |-> !rx_ctrl.fast_rate && $past(rx_ctrl.fast_rate);
  endproperty
  a_rate: assert property (p_rate) else $error("rate");
  property p_bclk;
    $rose(rx_ctrl.bit_clk) |-> rx_ctrl.bit_clk[*8] ##1 rx_ctrl.bit_clk[*8] ##1 !rx_ctrl.bit_clk;
  endproperty
  a_bclk: assert property (p_bclk) else $error("pulses");
  property p_sreset;
    rx_ctrl.shift_reset |-> rx_ctrl.fast_rate;
  endproperty
  a_sreset: assert property (p_sreset) else $error("shift reset");
  property p_eclr;
    ctl_wr && avs_writedata[8] && avs_byteenable[1] && !divisor.load |=> !end_irq_flag;
  endproperty
  a_eclr: assert property (p_eclr) else $error("end clear");
  property p_tclr;
    ctl_wr && avs_writedata[9] && avs_byteenable[1] |=> !timeout_irq_flag;
  endproperty
  a_tclr: assert property (p_tclr) else $error("timeout clear");
  c_load: cover property (divisor.load);
  c_bclk: cover property ($rose(rx_ctrl.bit_clk));
  c_end: cover property ($rose(end_irq_flag));
endmodule
bind aub_autobaud aub_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .divisor(divisor), .rx_ctrl(rx_ctrl),
  .end_irq_flag(end_irq_flag), .timeout_irq_flag(timeout_irq_flag));

// *** aub_term.sv ***
// Remote terminal sending one A character per send pulse.
// Assumes send is ignored while a frame is going out.
`timescale 1ns/1ns
module aub_term
#(
  parameter int BIT_CYC = 68
)
(
  input wire logic core_clk,
  input wire logic send,
  output logic rx_pin
);
  logic [9:0] frame;
  initial rx_pin = 1'h1;
  always @(posedge core_clk)
  begin
    if (send)
    begin
      frame = {1'h1, 8'h41, 1'h0};
      // Start bit, data LSB first, stop bit
      for (int i = 0; i < 10; i++)
      begin
        rx_pin <= frame[i];
        repeat (BIT_CYC) @(posedge core_clk);
      end
    end
  end
endmodule

// *** tb.sv ***
// Self-checking bench for the auto-baud unit.
// Assumes the terminal model drives the receive pin.
`timescale 1ns/1ns
module tb;
  import aub_pkg::*;
  localparam int BIT = 68;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [31:0] avs_address = 32'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_pin;
  logic send = 1'h0;
  aub_div_type divisor;
  aub_rx_ctrl_type rx_ctrl;
  logic end_irq_flag;
  logic timeout_irq_flag;
  logic [31:0] q;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  // Mode, end enable, expected divisor
  logic [17:0] rows [2] = '{{1'h0, 1'h1, 16'h0008}, {1'h1, 1'h0, 16'h0004}};
  aub_term #(.BIT_CYC(BIT)) u_term (.core_clk(core_clk), .send(send), .rx_pin(rx_pin));
  aub_autobaud u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .divisor(divisor),
    .rx_ctrl(rx_ctrl), .end_irq_flag(end_irq_flag), .timeout_irq_flag(timeout_irq_flag));
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0)
    begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic run_char(input logic [31:0] ctl);
    bus(1'h1, AUB_ADDR_CONTROL, ctl);
    bus(1'h0, AUB_ADDR_CONTROL, 32'h0);
    check(q[0], 1'h1);
    check(rx_ctrl.fast_rate, 1'h1);
    send <= 1'h1;
    @(posedge core_clk);
    send <= 1'h0;
  endtask
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    check(divisor.value, AUB_DIV_RESET);
    bus(1'h0, AUB_ADDR_CONTROL, 32'h0);
    check(q, AUB_CTL_RESET);
    for (int i = 0; i < 2; i++)
    begin
      bus(1'h1, AUB_ADDR_IRQ, {31'h0, rows[i][16]});
      run_char({30'h0, rows[i][17], 1'h1});
      n = 0;
      do
      begin
        bus(1'h0, AUB_ADDR_CONTROL, 32'h0);
        n++;
      end
      while (q[0] !== 1'h0 && n < 200);
      check(q[0], 1'h0);
      check(divisor.value, rows[i][15:0]);
      check(rx_ctrl.fast_rate, 1'h0);
      bus(1'h0, AUB_ADDR_DIVISOR, 32'h0);
      check(q, {16'h0, rows[i][15:0]});
      bus(1'h0, AUB_ADDR_IRQ, 32'h0);
      check(q[8], rows[i][16]);
      bus(1'h1, AUB_ADDR_CONTROL, 32'h0);
      check(end_irq_flag, rows[i][16]);
      bus(1'h1, AUB_ADDR_CONTROL, 32'h100);
      check(end_irq_flag, 1'h0);
      repeat (10 * BIT) @(posedge core_clk);
    end
    // Abandon a measurement mid start bit
    bus(1'h1, AUB_ADDR_IRQ, 32'h3);
    run_char(32'h3);
    repeat (40) @(posedge core_clk);
    bus(1'h1, AUB_ADDR_CONTROL, 32'h0);
    bus(1'h0, AUB_ADDR_CONTROL, 32'h0);
    check(q[0], 1'h0);
    check(rx_ctrl.fast_rate, 1'h0);
    repeat (12 * BIT) @(posedge core_clk);
    check(divisor.value, 16'h0004);
    check(end_irq_flag, 1'h0);
    bus(1'h1, AUB_ADDR_CONTROL, 32'h200);
    check(timeout_irq_flag, 1'h0);
    bus(1'h0, 32'h40008024, 32'h0);
    check(q, 32'h0);
    finish_test();
  end
endmodule
